/* pkg/imb_pkg.sv */
// package: register map, field layouts and states of the i2c master block
`default_nettype none
package imb_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0]  OFS_SCL_TIMING  = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_EN_CLR  = 8'h14;
  localparam logic [7:0]  OFS_IRQ_EN_SET  = 8'h16;
  localparam logic [7:0]  OFS_IRQ_FLAGS   = 8'h18;
  localparam logic [7:0]  OFS_BUS_STATUS  = 8'h1A;
  // ==========================================================
  // reset values and masks
  localparam logic [31:0] TIMING_RESET    = 32'h0000_0000;
  localparam logic [7:0]  IRQ_RESET       = 8'h00;
  localparam logic [15:0] STATUS_RESET    = 16'h0000;
  localparam logic [7:0]  IRQ_MASK        = 8'h83;
  localparam logic [15:0] STATUS_W1C_MASK = 16'h0743;
  localparam logic [7:0]  CNT_ZERO        = 8'h00;
  // ==========================================================
  // irq bit positions
  localparam int IRQ_ERROR = 7;
  localparam int IRQ_SB    = 1;
  localparam int IRQ_MB    = 0;
  // ==========================================================
  // status bit positions
  localparam int ST_LENGTH_ERROR = 10;
  localparam int ST_SEXT   = 9;
  localparam int ST_MEXT   = 8;
  localparam int ST_HOLD   = 7;
  localparam int ST_LOWT   = 6;
  localparam int ST_BS_HI  = 5;
  localparam int ST_BS_LO  = 4;
  localparam int ST_RECEIVED_NACK = 2;
  localparam int ST_ARB    = 1;
  localparam int ST_BUS_ERROR = 0;
  // ==========================================================
  // bus states and commands
  localparam logic [1:0] BUS_UNKNOWN = 2'h0;
  localparam logic [1:0] BUS_IDLE    = 2'h1;
  localparam logic [1:0] CMD_NONE    = 2'h0;
  // ==========================================================
  // link side synchroniser
  localparam int SYNC_BITS = 5;
  localparam int SY_TGL    = 0;
  localparam int SY_HOLD   = 1;
  localparam int SY_HS     = 2;
  localparam int SY_RUN    = 3;
  localparam int SY_SCL    = 4;
  // ==========================================================
  // types
  typedef struct packed {
    logic [7:0] fast_low_time;
    logic [7:0] fast_high_time;
    logic [7:0] normal_low_time;
    logic [7:0] normal_baud;
  } imb_timing_s;

  typedef struct packed {
    logic length_error;
    logic slave_extend_timeout;
    logic master_extend_timeout;
    logic scl_low_timeout;
    logic arbitration_lost;
    logic bus_error;
    logic rx_byte_ok;
    logic tx_byte_done;
    logic arb_lost_nack;
    logic start_unknown;
  } imb_evt_s;

  typedef enum logic [1:0] {
    SCL_IDLE = 2'b00,
    SCL_LOW  = 2'b01,
    SCL_HIGH = 2'b10
  } imb_scl_e;
endpackage
`default_nettype wire

/* design/imb_master.sv */
// i2c master: scl timing, interrupt enables, flags and status
//
// Functional notes
// R01: fast low field sets high-speed low time
// R02: fast low zero: fast high times all; here high and low only, bus free from normal baud
// R03: fast high field sets high-speed high time
// R04: nonzero normal low field sets low time
// R05: normal baud sets high, or both
// R06: enable-clear write one disables interrupt
// R07: enable-set write one enables interrupt
// R08: any error event sets error flag
// R09: good read byte sets slave flag, holds
// R10: releasing actions clear slave flag, release scl
// R11: writing one clears slave flag only
// R12: each written byte sets master flag
// R13: nack arbitration loss, unknown start set master
// R14: master flag without arbitration loss holds scl
// R15: writing one clears master flag always; a master set event in the same cycle wins
// R16: reserved bits read as zero
// R17: smart mode data read sends acknowledge
// R18: commands accepted only while a flag set
// R19: interrupt when flag and enable both set
`timescale 1ns/1ps
`default_nettype none
module imb_master (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              clk_link,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  input  wire imb_pkg::imb_evt_s evt,
  input  wire logic              cmd_wr,
  input  wire logic [1:0]        cmd_code,
  input  wire logic              addr_wr,
  input  wire logic              data_wr,
  input  wire logic              data_rd,
  input  wire logic              smart_mode_enable,
  input  wire logic              hs_mode,
  input  wire logic              scl_run,
  input  wire logic [1:0]        bus_state_a,
  input  wire logic              received_nack,
  input  wire logic              scl_in,
  output logic                   scl_o,
  output logic                   scl_oe,
  output logic                   irq,
  output logic                   clock_hold,
  output logic                   scl_release,
  output logic                   cmd_accept,
  output logic                   ack_send,
  output logic                   bus_force_idle
);
  // ==========================================================
  // system side state
  logic [31:0] timing_r, timing_nxt;
  logic [7:0]  en_r, en_nxt;
  logic [7:0]  flag_r, flag_nxt;
  logic [15:0] stat_r, stat_nxt;
  logic [15:0] stat_view;
  logic [31:0] rdata_r, rdata_nxt;
  logic        tgl_r, tgl_nxt;
  logic        hold_r, hold_nxt;
  logic        hs_r, hs_nxt;
  logic        run_r, run_nxt;
  logic        irq_r, irq_nxt;
  logic        rel_r, rel_nxt;
  logic        cacc_r, cacc_nxt;
  logic        ack_r, ack_nxt;
  logic        fidle_r, fidle_nxt;
  logic        release_any;
  logic        cmd_valid;
  logic        any_err;
  logic        wr_flags, wr_status;

  always_comb begin
    wr_flags  = reg_wr && (reg_addr == imb_pkg::OFS_IRQ_FLAGS);
    wr_status = reg_wr && (reg_addr == imb_pkg::OFS_BUS_STATUS);
    // R18 command gating
    cmd_valid = cmd_wr && (cmd_code != imb_pkg::CMD_NONE)
                && (flag_r[imb_pkg::IRQ_SB] || flag_r[imb_pkg::IRQ_MB]);
    // R10 releasing actions
    release_any = addr_wr || data_wr || cmd_valid
                  || (data_rd && smart_mode_enable);
    any_err = evt.length_error || evt.slave_extend_timeout
              || evt.master_extend_timeout || evt.scl_low_timeout
              || evt.arbitration_lost || evt.bus_error;
  end

  // ==========================================================
  // register writes, flags and status
  always_comb begin
    timing_nxt = timing_r;
    en_nxt     = en_r;
    tgl_nxt    = tgl_r;
    fidle_nxt  = 1'b0;
    if (reg_wr && (reg_addr == imb_pkg::OFS_SCL_TIMING)) begin
      timing_nxt = reg_wdata;
      tgl_nxt    = ~tgl_r;
    end
    // R06 write one disables
    if (reg_wr && (reg_addr == imb_pkg::OFS_IRQ_EN_CLR)) begin
      en_nxt = en_r & ~(reg_wdata[7:0] & imb_pkg::IRQ_MASK);
    end
    // R07 write one enables
    if (reg_wr && (reg_addr == imb_pkg::OFS_IRQ_EN_SET)) begin
      en_nxt = en_r | (reg_wdata[7:0] & imb_pkg::IRQ_MASK);
    end
    if (wr_status && (bus_state_a == imb_pkg::BUS_UNKNOWN)
        && (reg_wdata[imb_pkg::ST_BS_HI:imb_pkg::ST_BS_LO]
            == imb_pkg::BUS_IDLE)) begin
      fidle_nxt = 1'b1;
    end
    flag_nxt = flag_r;
    // R11 R15 write one clears flag
    if (wr_flags) begin
      flag_nxt = flag_r & ~(reg_wdata[7:0] & imb_pkg::IRQ_MASK);
    end
    // R10 release clears bus flags
    if (release_any) begin
      flag_nxt[imb_pkg::IRQ_SB] = 1'b0;
      flag_nxt[imb_pkg::IRQ_MB] = 1'b0;
    end
    // R08 error flag set
    if (any_err) begin
      flag_nxt[imb_pkg::IRQ_ERROR] = 1'b1;
    end
    // R09 slave flag set
    if (evt.rx_byte_ok) begin
      flag_nxt[imb_pkg::IRQ_SB] = 1'b1;
    end
    // R12 R13 master flag set
    if (evt.tx_byte_done || evt.arb_lost_nack || evt.start_unknown) begin
      flag_nxt[imb_pkg::IRQ_MB] = 1'b1;
    end
    stat_nxt = stat_r;
    if (wr_status) begin
      stat_nxt = stat_r & ~(reg_wdata[15:0] & imb_pkg::STATUS_W1C_MASK);
    end
    if (addr_wr) begin
      stat_nxt = imb_pkg::STATUS_RESET;
    end
    stat_nxt[imb_pkg::ST_LENGTH_ERROR] = stat_nxt[imb_pkg::ST_LENGTH_ERROR]
                                   | evt.length_error;
    stat_nxt[imb_pkg::ST_SEXT]   = stat_nxt[imb_pkg::ST_SEXT]
                                   | evt.slave_extend_timeout;
    stat_nxt[imb_pkg::ST_MEXT]   = stat_nxt[imb_pkg::ST_MEXT]
                                   | evt.master_extend_timeout;
    stat_nxt[imb_pkg::ST_LOWT]   = stat_nxt[imb_pkg::ST_LOWT]
                                   | evt.scl_low_timeout;
    stat_nxt[imb_pkg::ST_ARB]    = stat_nxt[imb_pkg::ST_ARB]
                                   | evt.arbitration_lost;
    stat_nxt[imb_pkg::ST_BUS_ERROR] = stat_nxt[imb_pkg::ST_BUS_ERROR]
                                   | evt.bus_error;
    // R09 R14 clock stretch level
    hold_nxt = flag_r[imb_pkg::IRQ_SB]
               || (flag_r[imb_pkg::IRQ_MB] && !stat_r[imb_pkg::ST_ARB]);
    hs_nxt   = hs_mode;
    run_nxt  = scl_run;
    // R19 interrupt output
    irq_nxt  = |(flag_r & en_r);
    rel_nxt  = release_any;
    cacc_nxt = cmd_valid;
    // R17 smart mode acknowledge
    ack_nxt  = data_rd && smart_mode_enable;
  end

  // ==========================================================
  // register read mux
  always_comb begin
    // R16 reserved bits zero
    stat_view = stat_r & imb_pkg::STATUS_W1C_MASK;
    stat_view[imb_pkg::ST_HOLD] = hold_r;
    stat_view[imb_pkg::ST_BS_HI:imb_pkg::ST_BS_LO] = bus_state_a;
    stat_view[imb_pkg::ST_RECEIVED_NACK] = received_nack;
    rdata_nxt = 32'h0000_0000;
    if (!reg_rd) begin
      rdata_nxt = 32'h0000_0000;
    end else if (reg_addr == imb_pkg::OFS_SCL_TIMING) begin
      rdata_nxt = timing_r;
    end else if ((reg_addr == imb_pkg::OFS_IRQ_EN_CLR)
                 || (reg_addr == imb_pkg::OFS_IRQ_EN_SET)) begin
      rdata_nxt = {24'h00_0000, en_r & imb_pkg::IRQ_MASK};
    end else if (reg_addr == imb_pkg::OFS_IRQ_FLAGS) begin
      rdata_nxt = {24'h00_0000, flag_r & imb_pkg::IRQ_MASK};
    end else if (reg_addr == imb_pkg::OFS_BUS_STATUS) begin
      rdata_nxt = {16'h0000, stat_view};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timing_r <= imb_pkg::TIMING_RESET;
      en_r     <= imb_pkg::IRQ_RESET;
      flag_r   <= imb_pkg::IRQ_RESET;
      stat_r   <= imb_pkg::STATUS_RESET;
      rdata_r  <= 32'h0000_0000;
      tgl_r    <= 1'b0;
      hold_r   <= 1'b0;
      hs_r     <= 1'b0;
      run_r    <= 1'b0;
      irq_r    <= 1'b0;
      rel_r    <= 1'b0;
      cacc_r   <= 1'b0;
      ack_r    <= 1'b0;
      fidle_r  <= 1'b0;
    end else begin
      timing_r <= timing_nxt;
      en_r     <= en_nxt;
      flag_r   <= flag_nxt;
      stat_r   <= stat_nxt;
      rdata_r  <= rdata_nxt;
      tgl_r    <= tgl_nxt;
      hold_r   <= hold_nxt;
      hs_r     <= hs_nxt;
      run_r    <= run_nxt;
      irq_r    <= irq_nxt;
      rel_r    <= rel_nxt;
      cacc_r   <= cacc_nxt;
      ack_r    <= ack_nxt;
      fidle_r  <= fidle_nxt;
    end
  end

  assign reg_rdata      = rdata_r;
  assign irq            = irq_r;
  assign clock_hold     = hold_r;
  assign scl_release    = rel_r;
  assign cmd_accept     = cacc_r;
  assign ack_send       = ack_r;
  assign bus_force_idle = fidle_r;

  // ==========================================================
  // link clock domain
  logic [2:0]                      lrst_r;
  logic                            lrst;
  logic [imb_pkg::SYNC_BITS-1:0]   sy_in, s1_r, s2_r, s3_r;
  logic [imb_pkg::SYNC_BITS-1:0]   filt_r, filt_nxt;
  logic                            tprev_r, tprev_nxt;
  imb_pkg::imb_timing_s            tl_r, tl_nxt;
  imb_pkg::imb_scl_e               st_r, st_nxt;
  logic [7:0]                      cnt_r, cnt_nxt;
  logic [7:0]                      low_fld, high_fld;
  logic                            oe_r, oe_nxt;

  always_ff @(posedge clk_link) begin
    lrst_r <= {lrst_r[1:0], rst};
  end
  assign lrst = lrst_r[2];

  always_comb begin
    sy_in = '0;
    sy_in[imb_pkg::SY_TGL]  = tgl_r;
    sy_in[imb_pkg::SY_HOLD] = hold_r;
    sy_in[imb_pkg::SY_HS]   = hs_r;
    sy_in[imb_pkg::SY_RUN]  = run_r;
    sy_in[imb_pkg::SY_SCL]  = scl_in;
  end

  // accept a change once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < imb_pkg::SYNC_BITS; gi = gi + 1) begin : g_filt
      assign filt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
    end
  endgenerate

  always_comb begin
    if (hs_filt_sel()) begin
      // R01 R02 R03 high-speed periods
      high_fld = tl_r.fast_high_time;
      low_fld  = (tl_r.fast_low_time != imb_pkg::CNT_ZERO)
                 ? tl_r.fast_low_time : tl_r.fast_high_time;
    end else begin
      // R04 R05 normal periods
      high_fld = tl_r.normal_baud;
      low_fld  = (tl_r.normal_low_time != imb_pkg::CNT_ZERO)
                 ? tl_r.normal_low_time : tl_r.normal_baud;
    end
  end

  function automatic logic hs_filt_sel();
    return filt_r[imb_pkg::SY_HS];
  endfunction

  always_comb begin
    tprev_nxt = filt_r[imb_pkg::SY_TGL];
    tl_nxt    = tl_r;
    if (filt_r[imb_pkg::SY_TGL] != tprev_r) begin
      tl_nxt = timing_r;
    end
    st_nxt  = st_r;
    cnt_nxt = cnt_r + 8'h01;
    case (st_r)
      imb_pkg::SCL_IDLE: begin
        // R02 bus free from normal baud
        if (cnt_r >= tl_r.normal_baud) begin
          cnt_nxt = cnt_r;
          if (filt_r[imb_pkg::SY_RUN]) begin
            st_nxt  = imb_pkg::SCL_LOW;
            cnt_nxt = imb_pkg::CNT_ZERO;
          end
        end
      end
      imb_pkg::SCL_LOW: begin
        if (cnt_r >= low_fld) begin
          cnt_nxt = cnt_r;
          // R09 R14 stretch while held
          if (!filt_r[imb_pkg::SY_HOLD]) begin
            st_nxt  = imb_pkg::SCL_HIGH;
            cnt_nxt = imb_pkg::CNT_ZERO;
          end
        end
      end
      imb_pkg::SCL_HIGH: begin
        if (!filt_r[imb_pkg::SY_SCL]) begin
          cnt_nxt = cnt_r;
        end else if (cnt_r >= high_fld) begin
          st_nxt  = filt_r[imb_pkg::SY_RUN] ? imb_pkg::SCL_LOW
                                            : imb_pkg::SCL_IDLE;
          cnt_nxt = imb_pkg::CNT_ZERO;
        end
      end
      default: begin
        st_nxt  = imb_pkg::SCL_IDLE;
        cnt_nxt = imb_pkg::CNT_ZERO;
      end
    endcase
    oe_nxt = (st_nxt == imb_pkg::SCL_LOW);
  end

  always_ff @(posedge clk_link) begin
    s1_r <= sy_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (lrst) begin
      filt_r  <= '0;
      tprev_r <= 1'b0;
      tl_r    <= imb_pkg::TIMING_RESET;
      st_r    <= imb_pkg::SCL_IDLE;
      cnt_r   <= imb_pkg::CNT_ZERO;
      oe_r    <= 1'b0;
    end else begin
      filt_r  <= filt_nxt;
      tprev_r <= tprev_nxt;
      tl_r    <= tl_nxt;
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      oe_r    <= oe_nxt;
    end
  end

  assign scl_o  = 1'b0;
  assign scl_oe = oe_r;

  // ==========================================================
  // checks
  a_low_bound: // R01
    assert property (@(posedge clk_link) disable iff (lrst)
      (st_r == imb_pkg::SCL_LOW) |-> (cnt_r <= low_fld))
    else $error("scl low count beyond selected field");
  a_en_clear: // R06
    assert property (@(posedge clk_sys) disable iff (rst)
      (reg_wr && reg_addr == imb_pkg::OFS_IRQ_EN_CLR
       && reg_wdata[imb_pkg::IRQ_MB])
      |=> !en_r[imb_pkg::IRQ_MB])
    else $error("enable clear did not disable");
  a_en_set: // R07
    assert property (@(posedge clk_sys) disable iff (rst)
      (reg_wr && reg_addr == imb_pkg::OFS_IRQ_EN_SET
       && reg_wdata[imb_pkg::IRQ_ERROR])
      |=> en_r[imb_pkg::IRQ_ERROR])
    else $error("enable set did not enable");
  a_err_flag: // R08
    assert property (@(posedge clk_sys) disable iff (rst)
      any_err |=> flag_r[imb_pkg::IRQ_ERROR])
    else $error("error event lost");
  a_sb_release: // R10
    assert property (@(posedge clk_sys) disable iff (rst)
      (release_any && !evt.rx_byte_ok) |=> ##1 !hold_r || $past(
        flag_r[imb_pkg::IRQ_MB]))
    else $error("slave flag hold not released");
  a_mb_set: // R12
    assert property (@(posedge clk_sys) disable iff (rst)
      evt.tx_byte_done |=> flag_r[imb_pkg::IRQ_MB] ##1 hold_r
        || stat_r[imb_pkg::ST_ARB] || $past(release_any))
    else $error("master flag or hold missing");
  a_reserved: // R16
    assert property (@(posedge clk_sys) disable iff (rst)
      ($past(reg_addr) == imb_pkg::OFS_BUS_STATUS)
      |-> (reg_rdata[31:11] == 21'h00_0000 && !reg_rdata[3]))
    else $error("reserved status bits not zero");
  a_smart_ack: // R17
    assert property (@(posedge clk_sys) disable iff (rst)
      (data_rd && smart_mode_enable) |=> ack_send && scl_release)
    else $error("smart read gave no acknowledge");
  a_cmd_gate: // R18
    assert property (@(posedge clk_sys) disable iff (rst)
      cmd_accept |-> $past(flag_r[imb_pkg::IRQ_SB]
                           || flag_r[imb_pkg::IRQ_MB]))
    else $error("command accepted without bus flag");
  a_irq_out: // R19
    assert property (@(posedge clk_sys) disable iff (rst)
      irq == $past(|(flag_r & en_r)))
    else $error("interrupt output mismatch");
endmodule // imb_master
`default_nettype wire

/* verif/imb_slave_model.sv */
// far-side model: scl pull-up with optional slave clock stretching
`timescale 1ns/1ps
`default_nettype none
module imb_slave_model #(
  parameter int STRETCH = 10
) (
  input  wire logic clk_link,
  input  wire logic scl_oe,
  input  wire logic scl_o,
  input  wire logic stretch_en,
  output logic      scl_in
);
  // ==========================================================
  // stretch timer
  logic prev_oe = 1'b0;
  int   cnt     = 0;
  logic start;
  assign start = stretch_en & prev_oe & ~scl_oe;
  always @(posedge clk_link) begin
    prev_oe <= scl_oe;
    if (start) begin
      cnt <= STRETCH;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // ==========================================================
  // wired-and line, pull-up when nobody drives
  assign scl_in = ~((scl_oe & ~scl_o) | start | (cnt > 0));
endmodule // imb_slave_model
`default_nettype wire

/* verif/testbench.sv */
// testbench: registers, flags, releases and scl timing of the master
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========================================================
  // signals
  logic              clk_sys, clk_link, rst, reg_wr, reg_rd;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, rd_v;
  imb_pkg::imb_evt_s evt;
  logic              cmd_wr, addr_wr, data_wr, data_rd, smart_mode_enable;
  logic [1:0]        cmd_code, bus_state_a;
  logic              hs_mode, scl_run, received_nack, scl_in, scl_o;
  logic              scl_oe, irq, clock_hold, scl_release, cmd_accept;
  logic              ack_send, bus_force_idle, stretch;
  int                error_cnt, total_checks, cyc, rel_n, ack_n, acc_n;
  int                idle_n, n, lo, hi;

  imb_master imb_master_i (
    .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .evt(evt), .cmd_wr(cmd_wr),
    .cmd_code(cmd_code), .addr_wr(addr_wr), .data_wr(data_wr),
    .data_rd(data_rd), .smart_mode_enable(smart_mode_enable),
    .hs_mode(hs_mode), .scl_run(scl_run), .bus_state_a(bus_state_a),
    .received_nack(received_nack), .scl_in(scl_in), .scl_o(scl_o),
    .scl_oe(scl_oe), .irq(irq), .clock_hold(clock_hold),
    .scl_release(scl_release), .cmd_accept(cmd_accept),
    .ack_send(ack_send), .bus_force_idle(bus_force_idle)
  );
  imb_slave_model imb_slave_model_i (
    .clk_link(clk_link), .scl_oe(scl_oe), .scl_o(scl_o),
    .stretch_en(stretch), .scl_in(scl_in)
  );
  // ==========================================================
  // clocks, pulse counters, timeout
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #1.3;
    forever #3 clk_link = ~clk_link;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (scl_release === 1'b1) rel_n++;
    if (ack_send === 1'b1) ack_n++;
    if (cmd_accept === 1'b1) acc_n++;
    if (bus_force_idle === 1'b1) idle_n++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic finish_test();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    rd_v = reg_rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(rd_v, exp);
  endtask
  task automatic ev(input logic [9:0] v);
    @(negedge clk_sys);
    evt = imb_pkg::imb_evt_s'(v);
    @(negedge clk_sys);
    evt = imb_pkg::imb_evt_s'(10'h000);
    repeat (2) @(negedge clk_sys);
  endtask
  // 0 address write, 1 data write, 2 data read, 3 command
  task automatic act(input int k);
    @(negedge clk_sys);
    addr_wr = (k == 0);
    data_wr = (k == 1);
    data_rd = (k == 2);
    cmd_wr = (k == 3);
    @(negedge clk_sys);
    {addr_wr, data_wr, data_rd, cmd_wr} = 4'h0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic measure();
    lo = 0;
    hi = 0;
    for (int i = 0; i < 400 && scl_oe !== 1'b0; i++) @(negedge clk_link);
    for (int i = 0; i < 400 && scl_oe !== 1'b1; i++) @(negedge clk_link);
    while (scl_oe === 1'b1 && lo < 400) begin
      @(negedge clk_link);
      lo++;
    end
    while (scl_oe === 1'b0 && hi < 400) begin
      @(negedge clk_link);
      hi++;
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rdchk(imb_pkg::OFS_SCL_TIMING, 32'h0);
    rdchk(imb_pkg::OFS_IRQ_EN_CLR, 32'h0);
    rdchk(imb_pkg::OFS_IRQ_EN_SET, 32'h0);
    rdchk(imb_pkg::OFS_IRQ_FLAGS, 32'h0);
    rdchk(imb_pkg::OFS_BUS_STATUS, 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    rdchk(8'h10, 32'h0);
  endtask
  task automatic t_timing();
    logic [32:0] tab [5];
    int el [5];
    int eh [5];
    tab = '{33'h0_0000_0305, 33'h0_0000_0005, 33'h1_0204_0007,
            33'h1_0004_0007, 33'h0_0000_0305};
    el = '{4, 6, 3, 5, 4};
    eh = '{6, 6, 5, 5, 16};
    for (int c = 0; c < 5; c++) begin
      wr(imb_pkg::OFS_SCL_TIMING, tab[c][31:0]);
      @(negedge clk_sys);
      hs_mode = tab[c][32];
      stretch = (c == 4);
      scl_run = 1'b1;
      repeat (60) @(negedge clk_link);
      measure();
      check(lo, el[c]);
      check(hi >= eh[c] && hi <= eh[c] + 8, 1);
      @(negedge clk_sys);
      scl_run = 1'b0;
      repeat (4) @(negedge clk_sys);
    end
    stretch = 1'b0;
    rdchk(imb_pkg::OFS_SCL_TIMING, 32'h0000_0305);
  endtask
  task automatic t_enable();
    wr(imb_pkg::OFS_IRQ_EN_SET, 32'hFF);
    rdchk(imb_pkg::OFS_IRQ_EN_SET, 32'h83);
    rdchk(imb_pkg::OFS_IRQ_EN_CLR, 32'h83);
    wr(imb_pkg::OFS_IRQ_EN_CLR, 32'h00);
    rdchk(imb_pkg::OFS_IRQ_EN_SET, 32'h83);
    wr(imb_pkg::OFS_IRQ_EN_CLR, 32'h81);
    rdchk(imb_pkg::OFS_IRQ_EN_SET, 32'h02);
    wr(imb_pkg::OFS_IRQ_EN_SET, 32'h00);
    rdchk(imb_pkg::OFS_IRQ_EN_CLR, 32'h02);
    wr(imb_pkg::OFS_IRQ_EN_SET, 32'h80);
    rdchk(imb_pkg::OFS_IRQ_EN_CLR, 32'h82);
  endtask
  task automatic t_error();
    for (int i = 4; i < 10; i++) begin
      ev(10'h001 << i);
      rd(imb_pkg::OFS_IRQ_FLAGS);
      check(rd_v & 32'h80, 32'h80);
      check(irq, 1'b1);
      wr(imb_pkg::OFS_IRQ_FLAGS, 32'h7C);
      rd(imb_pkg::OFS_IRQ_FLAGS);
      check(rd_v & 32'hFC, 32'h80);
      wr(imb_pkg::OFS_IRQ_FLAGS, 32'h83);
      rdchk(imb_pkg::OFS_IRQ_FLAGS, 32'h0);
      check(irq, 1'b0);
    end
    bus_state_a = imb_pkg::BUS_IDLE;
    received_nack = 1'b1;
    rdchk(imb_pkg::OFS_BUS_STATUS, 32'h0757);
    wr(imb_pkg::OFS_BUS_STATUS, 32'hFFCF);
    rdchk(imb_pkg::OFS_BUS_STATUS, 32'h0014);
    bus_state_a = imb_pkg::BUS_UNKNOWN;
    received_nack = 1'b0;
    wr(imb_pkg::OFS_BUS_STATUS, 32'h0010);
    repeat (2) @(negedge clk_sys);
    check(idle_n, 1);
  endtask
  task automatic t_slave();
    smart_mode_enable = 1'b1;
    cmd_code = 2'h3;
    for (int k = 0; k < 4; k++) begin
      ev(10'h008);
      rdchk(imb_pkg::OFS_IRQ_FLAGS, 32'h02);
      check(clock_hold, 1'b1);
      check(irq, 1'b1);
      n = rel_n;
      act(k);
      check(rel_n, n + 1);
      rdchk(imb_pkg::OFS_IRQ_FLAGS, 32'h0);
      check(clock_hold, 1'b0);
    end
    check(ack_n, 1);
    ev(10'h008);
    n = rel_n;
    wr(imb_pkg::OFS_IRQ_FLAGS, 32'h02);
    rdchk(imb_pkg::OFS_IRQ_FLAGS, 32'h0);
    check(rel_n, n);
    act(1);
    smart_mode_enable = 1'b0;
    ev(10'h008);
    act(2);
    rdchk(imb_pkg::OFS_IRQ_FLAGS, 32'h02);
    check(ack_n, 1);
    act(1);
  endtask
  task automatic t_master();
    n = acc_n;
    act(3);
    check(acc_n, n);
    ev(10'h004);
    rdchk(imb_pkg::OFS_IRQ_FLAGS, 32'h01);
    check(clock_hold, 1'b1);
    check(irq, 1'b0);
    cmd_code = 2'h0;
    act(3);
    check(acc_n, n);
    rdchk(imb_pkg::OFS_IRQ_FLAGS, 32'h01);
    cmd_code = 2'h1;
    act(3);
    check(acc_n, n + 1);
    rdchk(imb_pkg::OFS_IRQ_FLAGS, 32'h0);
    ev(10'h001);
    rdchk(imb_pkg::OFS_IRQ_FLAGS, 32'h01);
    wr(imb_pkg::OFS_IRQ_FLAGS, 32'h01);
    rdchk(imb_pkg::OFS_IRQ_FLAGS, 32'h0);
    act(1);
    ev(10'h022);
    rd(imb_pkg::OFS_IRQ_FLAGS);
    check(rd_v & 32'h01, 32'h01);
    check(clock_hold, 1'b0);
    wr(imb_pkg::OFS_IRQ_FLAGS, 32'h83);
    rdchk(imb_pkg::OFS_IRQ_FLAGS, 32'h0);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {rst, reg_wr, reg_rd, cmd_wr, addr_wr, data_wr, data_rd} = 7'h01 << 6;
    {smart_mode_enable, hs_mode, scl_run, received_nack, stretch} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    evt = imb_pkg::imb_evt_s'(10'h000);
    cmd_code = 2'h0;
    bus_state_a = 2'h0;
    {error_cnt, total_checks, cyc, rel_n, ack_n, acc_n, idle_n} = '0;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_timing();
    t_enable();
    t_error();
    t_slave();
    t_master();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
